// ---- rtl/on_off_delay_timer.sv ----
// Holds the constant package and the on-delay and off-delay timer pair with its APB slave.
// Assumes triggers, wipe and external delay values come from logic on clock_in,
// and that the surrounding logic routes the selected block's actual value in.
`timescale 1ns/1ps
package delay_timer_pkg;
  localparam int unsigned ADDR_W           = 8;
  localparam int unsigned DATA_W           = 32;
  localparam int unsigned SPAN_W           = 17;
  // Clock and timebase figures
  localparam int unsigned CLK_PERIOD_NS    = 8;
  localparam int unsigned MS_TIME_NS       = 1000000;
  localparam int unsigned MS_TICK_CYCLES   = (MS_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam logic [3:0]  MS_PER_FINE      = 4'd10;
  localparam logic [6:0]  FINE_PER_SEC     = 7'd100;
  localparam logic [5:0]  SEC_PER_MIN      = 6'd60;
  // Register byte offsets
  localparam logic [7:0]  OFS_ON_CTRL      = 8'h00;
  localparam logic [7:0]  OFS_ON_PARAM     = 8'h04;
  localparam logic [7:0]  OFS_OFF_CTRL     = 8'h08;
  localparam logic [7:0]  OFS_OFF_PARAM    = 8'h0c;
  localparam logic [7:0]  OFS_STATUS       = 8'h10;
  localparam logic [7:0]  OFS_ON_ELAPSED   = 8'h14;
  localparam logic [7:0]  OFS_OFF_ELAPSED  = 8'h18;
  localparam logic [7:0]  OFS_ON_LIMIT     = 8'h1c;
  localparam logic [7:0]  OFS_OFF_LIMIT    = 8'h20;
  // Control register fields
  localparam int unsigned CTRL_SRC_BIT     = 0;
  localparam int unsigned CTRL_TB_LSB      = 1;
  localparam int unsigned CTRL_RETAIN_BIT  = 3;
  localparam int unsigned CTRL_BLK_LSB     = 8;
  localparam logic [15:0] CTRL_RESET       = 16'h0000;
  // Parameter register fields: minor part low byte, major part high byte
  localparam int unsigned PARAM_MINOR_LSB  = 0;
  localparam int unsigned PARAM_MAJOR_LSB  = 8;
  localparam logic [15:0] PARAM_RESET      = 16'h0000;
  // Timebase codes
  localparam logic [1:0]  TB_FINE          = 2'd0;
  localparam logic [1:0]  TB_MID           = 2'd1;
  localparam logic [1:0]  TB_COARSE        = 2'd2;
  // Value limits
  localparam logic [7:0]  MAJOR_MAX        = 8'd99;
  localparam logic [7:0]  HUND_MAX         = 8'd99;
  localparam logic [7:0]  SIXTY_MAX        = 8'd59;
  localparam logic [16:0] EXT_MS_MAX       = 17'd99990;
  localparam logic [16:0] EXT_SM_MAX       = 17'd5999;
endpackage : delay_timer_pkg

module on_off_delay_timer #(
  parameter int unsigned MS_CYCLES = delay_timer_pkg::MS_TICK_CYCLES
) (
  input  wire logic                                 clock_in,
  input  wire logic                                 srst_in,
  // APB slave
  input  wire logic [delay_timer_pkg::ADDR_W-1:0]   paddr_in,
  input  wire logic                                 psel_in,
  input  wire logic                                 penable_in,
  input  wire logic                                 pwrite_in,
  input  wire logic [delay_timer_pkg::DATA_W-1:0]   pwdata_in,
  input  wire logic [3:0]                           pstrb_in,
  output logic [delay_timer_pkg::DATA_W-1:0]        prdata_out,
  output logic                                      pready_out,
  output logic                                      pslverr_out,
  // On-delay timer
  input  wire logic                                 on_trigger_in,
  input  wire logic [31:0]                          on_ext_value_in,
  output logic [7:0]                                on_block_sel_out,
  output logic                                      on_timer_out,
  // Off-delay timer
  input  wire logic                                 off_trigger_in,
  input  wire logic                                 off_wipe_in,
  input  wire logic [31:0]                          off_ext_value_in,
  output logic [7:0]                                off_block_sel_out,
  output logic                                      off_timer_out
);
  import delay_timer_pkg::*;

  // Byte-lane merge for APB writes
  function automatic logic [15:0] merge16(input logic [15:0] old_v,
                                          input logic [31:0] wdata,
                                          input logic [3:0]  strb);
    logic [15:0] r;
    r = old_v;
    if (strb[0]) r[7:0]  = wdata[7:0];
    if (strb[1]) r[15:8] = wdata[15:8];
    return r;
  endfunction : merge16

  function automatic logic [7:0] cap8(input logic [7:0] v, input logic [7:0] lim);
    return (v > lim) ? lim : v;
  endfunction : cap8

  // Effective delay in ticks of the selected timebase
  function automatic logic [SPAN_W-1:0] delay_limit(input logic        src_ext,
                                                    input logic [1:0]  tb,
                                                    input logic [15:0] param,
                                                    input logic [31:0] ext);
    logic [7:0]        major;
    logic [7:0]        minor;
    logic [SPAN_W-1:0] ext_max;
    logic [SPAN_W-1:0] r;
    major   = cap8(param[PARAM_MAJOR_LSB +: 8], MAJOR_MAX);
    minor   = param[PARAM_MINOR_LSB +: 8];
    ext_max = (tb == TB_FINE) ? EXT_MS_MAX : EXT_SM_MAX;
    r       = '0;
    if (src_ext) begin
      // Signed value: negative saturates to zero, large to the maximum
      if (ext[31]) r = '0;
      else if (ext[30:0] > 31'(ext_max)) r = ext_max;
      else r = ext[SPAN_W-1:0];
    end else if (tb == TB_FINE) begin
      // ss:hh in hundredths of a second
      r = SPAN_W'(major) * SPAN_W'(FINE_PER_SEC) + SPAN_W'(cap8(minor, HUND_MAX));
    end else begin
      // mm:ss in seconds or hh:mm in minutes
      r = SPAN_W'(major) * SPAN_W'(SEC_PER_MIN) + SPAN_W'(cap8(minor, SIXTY_MAX));
    end
    return r;
  endfunction : delay_limit

  // Tick that advances the count for a source and timebase
  function automatic logic tick_for(input logic       src_ext,
                                    input logic [1:0] tb,
                                    input logic       t_ms,
                                    input logic       t_fine,
                                    input logic       t_sec,
                                    input logic       t_min);
    logic r;
    if (tb == TB_FINE) r = src_ext ? t_ms : t_fine;
    else if (tb == TB_MID) r = t_sec;
    else r = t_min;
    return r;
  endfunction : tick_for

  logic        tick_ms;
  logic        tick_fine;
  logic        tick_sec;
  logic        tick_min;

  timebase_tick #(.MS_CYCLES(MS_CYCLES)) u_tick (
    .clock_in      (clock_in),
    .srst_in       (srst_in),
    .tick_ms_out   (tick_ms),
    .tick_fine_out (tick_fine),
    .tick_sec_out  (tick_sec),
    .tick_min_out  (tick_min)
  );

  // Register file
  logic [15:0] on_ctrl;
  logic [15:0] on_param;
  logic [15:0] off_ctrl;
  logic [15:0] off_param;

  wire         setup_phase = psel_in && !penable_in;
  wire         access_wr   = psel_in && penable_in && pwrite_in;
  wire         hit_on_ctrl = (paddr_in == OFS_ON_CTRL);
  wire         hit_on_par  = (paddr_in == OFS_ON_PARAM);
  wire         hit_off_ctl = (paddr_in == OFS_OFF_CTRL);
  wire         hit_off_par = (paddr_in == OFS_OFF_PARAM);
  wire         hit_status  = (paddr_in == OFS_STATUS);
  wire         hit_on_el   = (paddr_in == OFS_ON_ELAPSED);
  wire         hit_off_el  = (paddr_in == OFS_OFF_ELAPSED);
  wire         hit_on_lim  = (paddr_in == OFS_ON_LIMIT);
  wire         hit_off_lim = (paddr_in == OFS_OFF_LIMIT);
  wire         hit_rw      = hit_on_ctrl || hit_on_par || hit_off_ctl || hit_off_par;
  wire         hit_ro      = hit_status || hit_on_el || hit_off_el || hit_on_lim || hit_off_lim;
  // Writes to read-only words are refused with an error, like unmapped ones
  wire         addr_ok     = pwrite_in ? hit_rw : (hit_rw || hit_ro);

  wire         on_src_ext  = on_ctrl[CTRL_SRC_BIT];
  wire [1:0]   on_tb       = on_ctrl[CTRL_TB_LSB +: 2];
  wire         on_retain   = on_ctrl[CTRL_RETAIN_BIT];
  wire         off_src_ext = off_ctrl[CTRL_SRC_BIT];
  wire [1:0]   off_tb      = off_ctrl[CTRL_TB_LSB +: 2];
  wire         off_retain  = off_ctrl[CTRL_RETAIN_BIT];

  // Retain choice frozen while reset is held: the control words clear at the
  // first reset edge, so a long reset would otherwise drop retained state.
  logic        on_keep;
  logic        off_keep;
  always_ff @(posedge clock_in) begin
    if (!srst_in) begin
      on_keep  <= on_retain;
      off_keep <= off_retain;
    end
  end

  always_ff @(posedge clock_in) begin
    if (srst_in) begin
      on_ctrl   <= CTRL_RESET;
      on_param  <= PARAM_RESET;
      off_ctrl  <= CTRL_RESET;
      off_param <= PARAM_RESET;
    end else if (access_wr) begin
      if (hit_on_ctrl) on_ctrl <= merge16(on_ctrl, pwdata_in, pstrb_in);
      if (hit_on_par) on_param <= merge16(on_param, pwdata_in, pstrb_in);
      if (hit_off_ctl) off_ctrl <= merge16(off_ctrl, pwdata_in, pstrb_in);
      if (hit_off_par) off_param <= merge16(off_param, pwdata_in, pstrb_in);
    end
  end

  // The block number only steers the external selector outside this block
  assign on_block_sel_out  = on_ctrl[CTRL_BLK_LSB +: 8];
  assign off_block_sel_out = off_ctrl[CTRL_BLK_LSB +: 8];

  // Delay limits and count ticks
  wire [SPAN_W-1:0] on_limit  = delay_limit(on_src_ext, on_tb, on_param, on_ext_value_in);
  wire [SPAN_W-1:0] off_limit = delay_limit(off_src_ext, off_tb, off_param, off_ext_value_in);
  wire              on_tick   = tick_for(on_src_ext, on_tb, tick_ms, tick_fine, tick_sec,
                                         tick_min);
  wire              off_tick  = tick_for(off_src_ext, off_tb, tick_ms, tick_fine, tick_sec,
                                         tick_min);

  // On-delay timer
  logic             on_trg_q;
  logic             on_running;
  logic [SPAN_W-1:0] on_elapsed;
  wire              on_rise     = on_trigger_in && !on_trg_q;
  wire [SPAN_W-1:0] on_next_cnt = on_elapsed + SPAN_W'(1);
  wire              on_expire   = on_running && on_tick && (on_next_cnt >= on_limit);

  always_ff @(posedge clock_in) begin
    if (srst_in) begin
      on_trg_q <= 1'b0;
      // Tested this way round so an unknown flag at power-up clears the state
      if (on_keep) begin
        on_running   <= on_running;
      end else begin
        on_running   <= 1'b0;
        on_elapsed   <= '0;
        on_timer_out <= 1'b0;
      end
    end else begin
      on_trg_q <= on_trigger_in;
      if (!on_trigger_in) begin
        on_running   <= 1'b0;
        on_elapsed   <= '0;
        on_timer_out <= 1'b0;
      end else if (on_rise) begin
        on_elapsed   <= '0;
        // A zero delay expires at once
        on_running   <= (on_limit != '0);
        on_timer_out <= (on_limit == '0);
      end else if (on_expire) begin
        on_running   <= 1'b0;
        on_elapsed   <= on_limit;
        on_timer_out <= 1'b1;
      end else if (on_running && on_tick) begin
        on_elapsed <= on_next_cnt;
      end
    end
  end

  // Off-delay timer
  logic             off_trg_q;
  logic             off_running;
  logic [SPAN_W-1:0] off_elapsed;
  wire              off_fall     = !off_trigger_in && off_trg_q;
  wire [SPAN_W-1:0] off_next_cnt = off_elapsed + SPAN_W'(1);
  wire              off_expire   = off_running && off_tick && (off_next_cnt >= off_limit);

  always_ff @(posedge clock_in) begin
    if (srst_in) begin
      off_trg_q <= 1'b0;
      // Tested this way round so an unknown flag at power-up clears the state
      if (off_keep) begin
        off_running   <= off_running;
      end else begin
        off_running   <= 1'b0;
        off_elapsed   <= '0;
        off_timer_out <= 1'b0;
      end
    end else begin
      off_trg_q <= off_trigger_in;
      if (off_wipe_in) begin
        off_running   <= 1'b0;
        off_elapsed   <= '0;
        off_timer_out <= 1'b0;
      end else if (off_trigger_in) begin
        // A new pulse cancels a running count; expiry restarts at its end
        off_running   <= 1'b0;
        off_elapsed   <= '0;
        off_timer_out <= 1'b1;
      end else if (off_fall && off_timer_out) begin
        off_elapsed   <= '0;
        off_running   <= (off_limit != '0);
        off_timer_out <= (off_limit != '0);
      end else if (off_expire) begin
        off_running   <= 1'b0;
        off_elapsed   <= off_limit;
        off_timer_out <= 1'b0;
      end else if (off_running && off_tick) begin
        off_elapsed <= off_next_cnt;
      end
    end
  end

  // Read data and error are captured in the setup cycle; no wait states
  logic [DATA_W-1:0] next_rdata;
  assign next_rdata =
      hit_on_ctrl ? {16'h0000, on_ctrl} :
      hit_on_par  ? {16'h0000, on_param} :
      hit_off_ctl ? {16'h0000, off_ctrl} :
      hit_off_par ? {16'h0000, off_param} :
      hit_status  ? {28'h0000000, off_running, on_running, off_timer_out, on_timer_out} :
      hit_on_el   ? {15'h0000, on_elapsed} :
      hit_off_el  ? {15'h0000, off_elapsed} :
      hit_on_lim  ? {15'h0000, on_limit} :
      hit_off_lim ? {15'h0000, off_limit} :
      32'h00000000;

  logic err_q;
  always_ff @(posedge clock_in) begin
    if (srst_in) begin
      prdata_out <= '0;
      err_q      <= 1'b0;
    end else if (setup_phase) begin
      prdata_out <= pwrite_in ? 32'h00000000 : next_rdata;
      err_q      <= !addr_ok;
    end
  end

  assign pready_out  = 1'b1;
  assign pslverr_out = psel_in && penable_in && err_q;
endmodule : on_off_delay_timer

// ---- rtl/timebase_tick.sv ----
// Holds the shared timebase tick generator of the delay timer pair.
// Assumes the constant package is compiled first, one 125 MHz clock and a synchronous reset.
`timescale 1ns/1ps
module timebase_tick #(
  parameter int unsigned MS_CYCLES = delay_timer_pkg::MS_TICK_CYCLES
) (
  input  wire logic clock_in,
  input  wire logic srst_in,
  output logic      tick_ms_out,
  output logic      tick_fine_out,
  output logic      tick_sec_out,
  output logic      tick_min_out
);
  import delay_timer_pkg::*;

  logic [31:0] cyc;
  logic [3:0]  ms_cnt;
  logic [6:0]  fine_cnt;
  logic [5:0]  sec_cnt;
  wire         ms_wrap   = (cyc == 32'(MS_CYCLES - 1));
  wire         fine_wrap = ms_wrap && (ms_cnt == MS_PER_FINE - 4'd1);
  wire         sec_wrap  = fine_wrap && (fine_cnt == FINE_PER_SEC - 7'd1);
  wire         min_wrap  = sec_wrap && (sec_cnt == SEC_PER_MIN - 6'd1);

  // Ticks are cascaded so every coarser tick coincides with a finer one
  always_ff @(posedge clock_in) begin
    if (srst_in) begin
      cyc           <= '0;
      ms_cnt        <= '0;
      fine_cnt      <= '0;
      sec_cnt       <= '0;
      tick_ms_out   <= 1'b0;
      tick_fine_out <= 1'b0;
      tick_sec_out  <= 1'b0;
      tick_min_out  <= 1'b0;
    end else begin
      cyc           <= ms_wrap ? '0 : cyc + 32'd1;
      if (ms_wrap) ms_cnt <= fine_wrap ? '0 : ms_cnt + 4'd1;
      if (fine_wrap) fine_cnt <= sec_wrap ? '0 : fine_cnt + 7'd1;
      if (sec_wrap) sec_cnt <= min_wrap ? '0 : sec_cnt + 6'd1;
      tick_ms_out   <= ms_wrap;
      tick_fine_out <= fine_wrap;
      tick_sec_out  <= sec_wrap;
      tick_min_out  <= min_wrap;
    end
  end
endmodule : timebase_tick

// ---- dv/block_value_source.sv ----
// Stand-in for the function blocks whose actual values feed the timers.
// Assumes the block number is stable; the value follows it at once.
`timescale 1ns/1ps
module block_value_source (
  input  wire logic [7:0]  sel_in,
  output logic      [31:0] value_out
);
  // Values sit inside, above and below the clamp ranges
  always_comb begin
    case (sel_in)
      8'h01:   value_out = 32'h0000_0007;
      8'h02:   value_out = 32'h0003_0d40;
      8'h03:   value_out = 32'hffff_fff0;
      8'h04:   value_out = 32'h0000_1770;
      default: value_out = 32'h0000_0005;
    endcase
  end
endmodule : block_value_source

// ---- dv/delay_timer_monitor.sv ----
// Checker for the on/off delay timer pair, bound to its top module.
// Assumes one clock domain and the synchronous active-high reset.
`timescale 1ns/1ps
module delay_timer_monitor (
  input wire logic clock_in,
  input wire logic srst_in,
  input wire logic on_trigger_in,
  input wire logic on_timer_out,
  input wire logic off_trigger_in,
  input wire logic off_wipe_in,
  input wire logic off_timer_out
);
  default clocking cb @(posedge clock_in);
  endclocking
  default disable iff (srst_in);
  sequence s_off_high;
    off_trigger_in && !off_wipe_in;
  endsequence
  sequence s_off_fall;
    s_off_high ##1 (!off_trigger_in && !off_wipe_in);
  endsequence
  // Reset edges are excluded: retained state meets a cleared trigger history
  sequence s_after_run;
    !$past(srst_in);
  endsequence
  AST_ON_LOW: assert property (!on_trigger_in |=> !on_timer_out)
    else $error("on output high after trigger low");
  AST_ON_RISE: assert property ($rose(on_timer_out) and s_after_run |-> $past(on_trigger_in))
    else $error("on output rose without trigger");
  AST_ON_HOLD: assert property (on_timer_out && on_trigger_in && !$past(srst_in) |=> on_timer_out)
    else $error("on output dropped with trigger high");
  AST_OFF_SET: assert property (s_off_high |=> off_timer_out)
    else $error("off output not set by trigger");
  AST_OFF_HOLD: assert property (s_off_fall |-> off_timer_out)
    else $error("off output low at trigger fall");
  AST_OFF_WIPE: assert property (off_wipe_in |=> !off_timer_out)
    else $error("off output high under wipe");
  AST_OFF_RISE: assert property ($rose(off_timer_out) and s_after_run |-> $past(off_trigger_in))
    else $error("off output rose without trigger");
  AST_OFF_FALL: assert property ($fell(off_timer_out) and s_after_run
    |-> !$past(off_trigger_in) || $past(off_wipe_in))
    else $error("off output fell with trigger high");
endmodule : delay_timer_monitor

bind on_off_delay_timer delay_timer_monitor u_delay_timer_monitor (
  .clock_in       (clock_in),
  .srst_in        (srst_in),
  .on_trigger_in  (on_trigger_in),
  .on_timer_out   (on_timer_out),
  .off_trigger_in (off_trigger_in),
  .off_wipe_in    (off_wipe_in),
  .off_timer_out  (off_timer_out)
);

// ---- dv/on_off_delay_timer_tb.sv ----
// Self-checking bench for the delay timer pair, driven over APB.
// Assumes a shortened 1 ms tick of 4 clocks, so a 10 ms tick is 40 clocks.
`timescale 1ns/1ps
module on_off_delay_timer_tb;
  import delay_timer_pkg::*;
  localparam int unsigned MS_C = 4;
  localparam logic [15:0] T_CTRL [11] = '{16'h0000, 16'h0002, 16'h0002, 16'h0000, 16'h0004,
    16'h0006, 16'h0101, 16'h0201, 16'h0301, 16'h0203, 16'h0405};
  localparam logic [15:0] T_PAR [11] = '{16'h0205, 16'h0205, 16'h0163, 16'hff00, 16'h0102,
    16'h0102, 16'h0000, 16'h0000, 16'h0000, 16'h0000, 16'h0000};
  localparam logic [16:0] T_LIM [11] = '{17'h000cd, 17'h0007d, 17'h00077, 17'h026ac,
    17'h0003e, 17'h0003e, 17'h00007, 17'h18696, 17'h00000, 17'h0176f, 17'h0176f};
  logic        clock_in       = 1'h0;
  logic        srst_in        = 1'h1;
  logic [7:0]  paddr_in       = 8'h00;
  logic        psel_in        = 1'h0;
  logic        penable_in     = 1'h0;
  logic        pwrite_in      = 1'h0;
  logic [31:0] pwdata_in      = 32'h0;
  logic        on_trigger_in  = 1'h0;
  logic        off_trigger_in = 1'h0;
  logic        off_wipe_in    = 1'h0;
  logic [31:0] prdata_out, on_ext_value_in, off_ext_value_in, rd;
  logic [7:0]  on_block_sel_out, off_block_sel_out;
  logic        pready_out, pslverr_out, on_timer_out, off_timer_out, er;
  int          n_mismatch     = 0;
  int          tests_run      = 0;
  int          cyc            = 0;

  always #4 clock_in = ~clock_in;

  on_off_delay_timer #(.MS_CYCLES(MS_C)) u_on_off_delay_timer (
    .clock_in(clock_in), .srst_in(srst_in), .paddr_in(paddr_in), .psel_in(psel_in),
    .penable_in(penable_in), .pwrite_in(pwrite_in), .pwdata_in(pwdata_in),
    .pstrb_in(4'hf), .prdata_out(prdata_out), .pready_out(pready_out),
    .pslverr_out(pslverr_out), .on_trigger_in(on_trigger_in),
    .on_ext_value_in(on_ext_value_in), .on_block_sel_out(on_block_sel_out),
    .on_timer_out(on_timer_out), .off_trigger_in(off_trigger_in),
    .off_wipe_in(off_wipe_in), .off_ext_value_in(off_ext_value_in),
    .off_block_sel_out(off_block_sel_out), .off_timer_out(off_timer_out));
  block_value_source u_block_value_source_on (.sel_in(on_block_sel_out),
    .value_out(on_ext_value_in));
  block_value_source u_block_value_source_off (.sel_in(off_block_sel_out),
    .value_out(off_ext_value_in));

  task stop_test();
    $display("Comparisons %0d, mismatches %0d", tests_run, n_mismatch);
    if (n_mismatch == 0 && tests_run > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask : stop_test

  // A hang ends the run through the same closing report
  always @(posedge clock_in) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      n_mismatch++;
      stop_test();
    end
  end

  task chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    tests_run++;
    if (got !== exp) begin
      n_mismatch++;
      $display("[ERR] %s expected %h seen %h", what, exp, got);
    end
  endtask : chk

  task acc(input logic wr, input logic [7:0] a, input logic [31:0] d, input logic e);
    @(posedge clock_in);
    psel_in <= 1'h1;
    pwrite_in <= wr;
    paddr_in <= a;
    pwdata_in <= d;
    @(posedge clock_in);
    penable_in <= 1'h1;
    do @(posedge clock_in); while (pready_out !== 1'h1);
    rd = prdata_out;
    er = pslverr_out;
    psel_in <= 1'h0;
    penable_in <= 1'h0;
    chk("pslverr", {31'h0, e}, {31'h0, er});
  endtask : acc

  task rchk(input string what, input logic [7:0] a, input logic [31:0] exp);
    acc(1'h0, a, 32'h0, 1'h0);
    chk(what, exp, rd);
  endtask : rchk

  task wait_c(input int n);
    repeat (n) @(posedge clock_in);
  endtask : wait_c

  task do_reset();
    srst_in <= 1'h1;
    wait_c(16);
    srst_in <= 1'h0;
  endtask : do_reset

  initial begin
    do_reset();
    rchk("on_ctrl", OFS_ON_CTRL, 32'h0);
    rchk("status", OFS_STATUS, 32'h0);
    acc(1'h0, 8'h24, 32'h0, 1'h1);
    acc(1'h1, OFS_STATUS, 32'h1, 1'h1);
    for (int i = 0; i < 11; i++) begin
      acc(1'h1, OFS_ON_CTRL, {16'h0, T_CTRL[i]}, 1'h0);
      acc(1'h1, OFS_ON_PARAM, {16'h0, T_PAR[i]}, 1'h0);
      rchk("on_limit", OFS_ON_LIMIT, {15'h0, T_LIM[i]});
      chk("block_sel", {24'h0, T_CTRL[i][15:8]}, {24'h0, on_block_sel_out});
    end
    acc(1'h1, OFS_ON_CTRL, 32'h0, 1'h0);
    acc(1'h1, OFS_ON_PARAM, 32'h2, 1'h0);
    on_trigger_in <= 1'h1;
    wait_c(35);
    chk("on_out", 32'h0, {31'h0, on_timer_out});
    wait_c(55);
    chk("on_out", 32'h1, {31'h0, on_timer_out});
    rchk("on_elapsed", OFS_ON_ELAPSED, 32'h2);
    rchk("status", OFS_STATUS, 32'h1);
    on_trigger_in <= 1'h0;
    wait_c(2);
    chk("on_out", 32'h0, {31'h0, on_timer_out});
    on_trigger_in <= 1'h1;
    wait_c(30);
    on_trigger_in <= 1'h0;
    rchk("on_elapsed", OFS_ON_ELAPSED, 32'h0);
    wait_c(100);
    chk("on_out", 32'h0, {31'h0, on_timer_out});
    acc(1'h1, OFS_OFF_CTRL, 32'h0201, 1'h0);
    rchk("off_limit", OFS_OFF_LIMIT, 32'h18696);
    chk("off_sel", 32'h2, {24'h0, off_block_sel_out});
    acc(1'h1, OFS_OFF_CTRL, 32'h0, 1'h0);
    acc(1'h1, OFS_OFF_PARAM, 32'h2, 1'h0);
    off_trigger_in <= 1'h1;
    wait_c(2);
    chk("off_out", 32'h1, {31'h0, off_timer_out});
    off_trigger_in <= 1'h0;
    wait_c(35);
    chk("off_out", 32'h1, {31'h0, off_timer_out});
    off_trigger_in <= 1'h1;
    wait_c(1);
    off_trigger_in <= 1'h0;
    wait_c(35);
    chk("off_out", 32'h1, {31'h0, off_timer_out});
    wait_c(55);
    chk("off_out", 32'h0, {31'h0, off_timer_out});
    rchk("off_elapsed", OFS_OFF_ELAPSED, 32'h2);
    off_trigger_in <= 1'h1;
    wait_c(2);
    off_trigger_in <= 1'h0;
    wait_c(10);
    off_wipe_in <= 1'h1;
    wait_c(2);
    chk("off_out", 32'h0, {31'h0, off_timer_out});
    off_trigger_in <= 1'h1;
    wait_c(3);
    chk("off_out", 32'h0, {31'h0, off_timer_out});
    off_trigger_in <= 1'h0;
    off_wipe_in <= 1'h0;
    acc(1'h1, OFS_OFF_CTRL, 32'h8, 1'h0);
    off_trigger_in <= 1'h1;
    wait_c(2);
    off_trigger_in <= 1'h0;
    wait_c(5);
    do_reset();
    chk("off_out", 32'h1, {31'h0, off_timer_out});
    rchk("off_ctrl", OFS_OFF_CTRL, 32'h0);
    wait_c(100);
    chk("off_out", 32'h0, {31'h0, off_timer_out});
    acc(1'h1, OFS_OFF_PARAM, 32'h2, 1'h0);
    off_trigger_in <= 1'h1;
    wait_c(2);
    off_trigger_in <= 1'h0;
    wait_c(5);
    do_reset();
    chk("off_out", 32'h0, {31'h0, off_timer_out});
    stop_test();
  end
endmodule : on_off_delay_timer_tb
